// ==== tank_remote_time_slot_codec_bench.sv ====
// Self-checking bench for the tank remote codec
`timescale 1ns/100ps
module tank_remote_time_slot_codec_bench;
  import trc_pkg::*;
  typedef struct packed {logic [3:0] d1, d2; logic f1, f2;
    logic [10:0] c1, c2;} trc_tx_row_type;
  localparam trc_tx_row_type TX [6] = '{
    '{4'h0, 4'h1, 1'b0, 1'b1, 11'h6ef, 11'h7b7},
    '{4'h1, 4'h0, 1'b1, 1'b0, 11'h7d7, 11'h3fe},
    '{4'h2, 4'h4, 1'b0, 1'b0, 11'h6fe, 11'h5fd},
    '{4'h4, 4'h8, 1'b1, 1'b1, 11'h7dd, 11'h7bb},
    '{4'h8, 4'h0, 1'b0, 1'b1, 11'h6fb, 11'h77e},
    '{4'h0, 4'h2, 1'b1, 1'b0, 11'h7cf, 11'h5fe}};
  localparam logic [4:0] RXC [10] = '{5'h11, 5'h08, 5'h16, 5'h0f, 5'h15,
    5'h0c, 5'h12, 5'h0b, 5'h18, 5'h07};
  localparam logic [3:0] RXT [10] = '{4'h5, 4'h5, 4'ha, 4'ha, 4'h6, 4'h6,
    4'h9, 4'h9, 4'h0, 4'h0};
  logic        mclk, reset_n, rst_req, fire1, fire2, stb_p1, grst_seen;
  logic [3:0]  dir1, dir2, shared, trk1, trk2, wstrb;
  logic        s1, s2, fo1, fo2, stb1, stb2, grst;
  logic [10:0] enc_n;
  logic [4:0]  code, e1, e2;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          bad_count = 0, cmp_count = 0, stb_n = 0, cyc = 0, n0;
  trc_codec #(.REF_DIV_P(4), .SETTLE_CYC_P(4)) trc_codec_inst (
    .mclk(mclk), .reset_n(reset_n), .first_player_direction_in(dir1),
    .second_player_direction_in(dir2), .first_player_fire(fire1),
    .second_player_fire(fire2), .game_reset_request(rst_req),
    .shared_direction_lines(shared), .first_slot(s1), .second_slot(s2),
    .encoder_code_n(enc_n), .received_code(code),
    .first_player_tracks(trk1), .second_player_tracks(trk2),
    .first_player_fire_out(fo1), .second_player_fire_out(fo2),
    .first_player_strobe(stb1), .second_player_strobe(stb2),
    .game_reset_out(grst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  trc_rx_model trc_rx_model_inst (.code_pins(code), .mclk(mclk));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic axi(input logic wr, input logic [31:0] a, d, ed,
                     input logic [1:0] er);
    @(posedge mclk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= wr;
    wvalid  <= wr;
    bready  <= wr;
    arvalid <= !wr;
    rready  <= !wr;
    do @(posedge mclk); while (wr ? !awready : !arready);
    {awvalid, wvalid, arvalid} <= '0;
    while (wr ? !bvalid : !rvalid) @(posedge mclk);
    check(32'(wr ? bresp : rresp), 32'(er));
    if (!wr) check(rdata, ed);
    {bready, rready} <= '0;
  endtask
  // Fresh slot entry, so a row never straddles a toggle
  task automatic wait_slot(input logic x);
    while (s1 === x) @(posedge mclk);
    while (s1 !== x) @(posedge mclk);
    repeat (6) @(posedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (stb1 || stb2) stb_n <= stb_n + 1;
    if (stb1 || stb2) stb_p1 <= stb1;
    if (grst) grst_seen <= 1'b1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end
  initial begin
    reset_n = 1'b0;
    wstrb = 4'hf;
    {rst_req, fire1, fire2, dir1, dir2, grst_seen} = '0;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    axi(0, 32'(REG_CTRL), 0, CTRL_RESET, RESP_OKAY);
    axi(0, 32'(REG_STATUS), 0, 32'(TX[0].c1), RESP_OKAY);
    axi(1, 32'h8, 32'h1, 0, RESP_SLVERR);
    axi(0, 32'h8, 0, 0, RESP_SLVERR);
    axi(1, 32'(REG_STATUS), 32'h0, 0, RESP_OKAY);
    axi(1, 32'(REG_CTRL), 32'h0, 0, RESP_OKAY);
    axi(0, 32'(REG_CTRL), 0, 0, RESP_OKAY);
    n0 = stb_n;
    trc_rx_model_inst.send(5'h10, 23, 162);
    check(32'(stb_n - n0), 0);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    check(32'({trk1, trk2, stb1, stb2, grst, s1, s2}), 32'h2);
    check(32'(enc_n), 32'h7ff);
    reset_n <= 1'b1;
    axi(0, 32'(REG_CTRL), 0, CTRL_RESET, RESP_OKAY);
    e1 = '0;
    e2 = '0;
    for (int i = 0; i < 10; i++) begin
      n0 = stb_n;
      if (RXC[i][4]) e1 = {RXC[i][0], RXT[i]};
      else e2 = {RXC[i][0], RXT[i]};
      trc_rx_model_inst.send(RXC[i], 23, 162);
      check(32'(stb_n - n0), 1);
      check(32'(stb_p1), 32'(RXC[i][4]));
      check(32'({fo1, trk1}), 32'(e1));
      check(32'({fo2, trk2}), 32'(e2));
    end
    n0 = stb_n;
    trc_rx_model_inst.send(5'h10, 3, 20);
    check(32'(stb_n - n0), 0);
    grst_seen <= 1'b0;
    trc_rx_model_inst.send(5'h05, 23, 10);
    check(32'({grst_seen, grst}), 32'h2);
    check(32'(stb_n - n0), 0);
    wait_slot(1'b1);
    n0 = 6;
    while (s1 === 1'b1) begin
      @(posedge mclk);
      n0++;
    end
    check(32'(n0), 32'(100 * 4));
    for (int i = 0; i < 6; i++) begin
      dir1 <= TX[i].d1;
      dir2 <= TX[i].d2;
      fire1 <= TX[i].f1;
      fire2 <= TX[i].f2;
      wait_slot(1'b1);
      check(32'(shared), 32'(TX[i].d1));
      check(32'(enc_n), 32'(TX[i].c1));
      wait_slot(1'b0);
      check(32'(shared), 32'(TX[i].d2));
      check(32'(enc_n), 32'(TX[i].c2));
    end
    rst_req <= 1'b1;
    wait_slot(1'b1);
    check(32'(enc_n), 32'h77d);
    wait_slot(1'b0);
    check(32'(enc_n), 32'(TX[5].c2));
    end_sim();
  end
endmodule

// ==== trc_codec.sv ====
// Tank remote transmitter slot encoder and receiver code decoder
`timescale 1ns/100ps

// How it works
// - 500 Hz reference, two decade dividers, then a toggle flip-flop.
// - Toggle gives two exclusive alternating 200 ms player slots.
// - Reset switch seizes slot one to send the game reset code.
// - Shared direction lines carry player one in slot one, two in two.
// - Directions, slots, reset, fires combine into active-low encoder code.
// - Every state, stopped included, yields a nonzero code each slot.
// - Codes arrive as about 23 ms pulses every 185 ms.
// - Code decodes to four track signals, two strobes, game reset.
// - Track signals latch on the strobe of the addressed player.
// - Latched tracks drive the game chip's control switches.
module trc_codec
  import trc_pkg::*;
#(
  parameter int unsigned REF_DIV_P    = REF_DIV,    // Cycles per 500 Hz tick
  parameter int unsigned SETTLE_CYC_P = SETTLE_CYC  // Code settle cycles
) (
  input  wire logic        mclk,                       // 20 MHz clock
  input  wire logic        reset_n,                    // Sync reset
  input  wire logic [3:0]  first_player_direction_in,  // Player one switches
  input  wire logic [3:0]  second_player_direction_in, // Player two switches
  input  wire logic        first_player_fire,          // Player one fire
  input  wire logic        second_player_fire,         // Player two fire
  input  wire logic        game_reset_request,         // Reset switch
  output logic [3:0]       shared_direction_lines,     // Muxed directions
  output logic             first_slot,                 // Slot one active
  output logic             second_slot,                // Slot two active
  output logic [10:0]      encoder_code_n,             // Encoder inputs
  input  wire logic [4:0]  received_code,              // Decoder code pins
  output logic [3:0]       first_player_tracks,        // Player one switches
  output logic [3:0]       second_player_tracks,       // Player two switches
  output logic             first_player_fire_out,      // Player one fire
  output logic             second_player_fire_out,     // Player two fire
  output logic             first_player_strobe,        // Player one strobe
  output logic             second_player_strobe,       // Player two strobe
  output logic             game_reset_out,             // Game reset
  input  wire logic [31:0] s_axi_awaddr,               // Write address
  input  wire logic        s_axi_awvalid,              // Write addr valid
  output logic             s_axi_awready,              // Write addr ready
  input  wire logic [31:0] s_axi_wdata,                // Write data
  input  wire logic [3:0]  s_axi_wstrb,                // Write strobes
  input  wire logic        s_axi_wvalid,               // Write data valid
  output logic             s_axi_wready,               // Write data ready
  output logic [1:0]       s_axi_bresp,                // Write response
  output logic             s_axi_bvalid,               // Write resp valid
  input  wire logic        s_axi_bready,               // Write resp ready
  input  wire logic [31:0] s_axi_araddr,               // Read address
  input  wire logic        s_axi_arvalid,              // Read addr valid
  output logic             s_axi_arready,              // Read addr ready
  output logic [31:0]      s_axi_rdata,                // Read data
  output logic [1:0]       s_axi_rresp,                // Read response
  output logic             s_axi_rvalid,               // Read data valid
  input  wire logic        s_axi_rready                // Read data ready
);

  typedef struct packed {
    logic [1:0][3:0] dir1_sync;
    logic [1:0][3:0] dir2_sync;
    logic [1:0][2:0] misc_sync;    // Fire one, fire two, reset
    logic [1:0][4:0] code_sync;
    logic [15:0]     ref_cnt;
    logic [3:0]      dec1;
    logic [3:0]      dec2;
    logic            slot_tog;
    logic [3:0]      shared;
    logic [10:0]     enc_n;
    logic [4:0]      code_prev;
    logic [15:0]     settle_cnt;
    logic            accepted;
    logic [3:0]      trk1;
    logic [3:0]      trk2;
    logic            fire1;
    logic            fire2;
    logic            stb1;
    logic            stb2;
    logic            greset;
    logic [31:0]     ctrl;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
  } trc_state_type;

  trc_state_type s_q;
  trc_state_type s_d;

  // Track pattern for a direction field
  function automatic logic [3:0] trc_tracks(input logic [2:0] dir,
                                            input logic       p1);
    logic [3:0] t;
    t = 4'h0;
    if (dir == (p1 ? P1_FWD : P2_FWD)) begin
      t[TRK_LF] = 1'b1;
      t[TRK_RF] = 1'b1;
    end else if (dir == (p1 ? P1_REV : P2_REV)) begin
      t[TRK_LR] = 1'b1;
      t[TRK_RR] = 1'b1;
    end else if (dir == (p1 ? P1_LEFT : P2_LEFT)) begin
      t[TRK_RF] = 1'b1;
      t[TRK_LR] = 1'b1;
    end else if (dir == (p1 ? P1_RIGHT : P2_RIGHT)) begin
      t[TRK_LF] = 1'b1;
      t[TRK_RR] = 1'b1;
    end
    return t;
  endfunction

  always_comb begin
    logic [3:0]       dirs;
    logic             moving;
    logic             ref_tick;
    logic             tick1;
    logic             tick2;
    logic [ENC_W-1:0] e;
    logic [2:0]       dfield;
    logic             wr_go;
    logic             rd_go;
    dirs     = 4'h0;
    moving   = 1'b0;
    ref_tick = 1'b0;
    tick1    = 1'b0;
    tick2    = 1'b0;
    e        = '0;
    dfield   = 3'h0;
    wr_go    = 1'b0;
    rd_go    = 1'b0;
    s_d      = s_q;

    // -------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------
    s_d.dir1_sync = {s_q.dir1_sync[0], first_player_direction_in};
    s_d.dir2_sync = {s_q.dir2_sync[0], second_player_direction_in};
    s_d.misc_sync = {s_q.misc_sync[0], {first_player_fire,
                     second_player_fire, game_reset_request}};
    s_d.code_sync = {s_q.code_sync[0], received_code};

    // -------------------------------------------------------------
    // Timing chain
    // -------------------------------------------------------------
    if (s_q.ref_cnt == 16'(REF_DIV_P - 1)) begin
      s_d.ref_cnt = '0;
      ref_tick    = 1'b1;
    end else begin
      s_d.ref_cnt = s_q.ref_cnt + 16'h0001;
    end
    if (ref_tick) begin
      tick1   = (s_q.dec1 == DECADE_LAST);
      s_d.dec1 = tick1 ? 4'h0 : s_q.dec1 + 4'h1;
    end
    if (tick1) begin
      tick2   = (s_q.dec2 == DECADE_LAST);
      s_d.dec2 = tick2 ? 4'h0 : s_q.dec2 + 4'h1;
    end
    // Toggle every 100 pulses gives 200 ms per slot
    if (tick2) begin
      s_d.slot_tog = ~s_q.slot_tog;
    end

    // -------------------------------------------------------------
    // Player multiplexer and encoder
    // -------------------------------------------------------------
    s_d.shared = s_q.slot_tog ? s_q.dir2_sync[1] : s_q.dir1_sync[1];
    dirs   = s_q.shared;
    moving = |dirs;
    // Encoding runs in every slot; the stopped tank has its own code
    if (!s_q.slot_tog && s_q.misc_sync[1][0]) begin
      e[ENC_B] = 1'b1;
      e[ENC_H] = 1'b1;
    end else begin
      e[ENC_A] = dirs[DIR_REV];
      e[ENC_B] = dirs[DIR_LEFT];
      e[ENC_C] = dirs[DIR_RIGHT];
      e[ENC_D] = dirs[DIR_FWD];
      if (!s_q.slot_tog) begin
        e[ENC_E] = ~moving;
        e[ENC_F] = s_q.misc_sync[1][2];
        e[ENC_J] = ~s_q.misc_sync[1][2];
      end else if (moving) begin
        e[ENC_G] = s_q.misc_sync[1][1];
        e[ENC_K] = ~s_q.misc_sync[1][1];
      end else begin
        e[ENC_A] = 1'b1;
        e[ENC_H] = s_q.misc_sync[1][1];
        e[ENC_L] = ~s_q.misc_sync[1][1];
      end
    end
    s_d.enc_n = ~e;

    // -------------------------------------------------------------
    // Receiver decoding
    // -------------------------------------------------------------
    s_d.stb1      = 1'b0;
    s_d.stb2      = 1'b0;
    s_d.code_prev = s_q.code_sync[1];
    dfield        = s_q.code_sync[1][CODE_DIR_HI:CODE_DIR_LO];
    // Every valid code is nonzero, so zero means no pulse
    if (s_q.code_sync[1] == 5'h00) begin
      s_d.settle_cnt = '0;
      s_d.accepted   = 1'b0;
      s_d.greset     = 1'b0;
    end else if (s_q.code_sync[1] != s_q.code_prev) begin
      // Bits may skew at pulse edges; restart the settle time
      s_d.settle_cnt = '0;
    end else if (s_q.settle_cnt != 16'(SETTLE_CYC_P)) begin
      s_d.settle_cnt = s_q.settle_cnt + 16'h0001;
    end else if (!s_q.accepted && s_q.ctrl[CTRL_RX_EN]) begin
      s_d.accepted = 1'b1;
      if (s_q.code_sync[1][CODE_PLAYER]) begin
        s_d.stb1  = 1'b1;
        s_d.trk1  = trc_tracks(dfield, 1'b1);
        s_d.fire1 = s_q.code_sync[1][CODE_FIRE];
      end else if (dfield == P2_RESET) begin
        s_d.greset = 1'b1;
      end else begin
        s_d.stb2  = 1'b1;
        s_d.trk2  = trc_tracks(dfield, 1'b0);
        s_d.fire2 = s_q.code_sync[1][CODE_FIRE];
      end
    end
    // Tracks not addressed keep their value

    // -------------------------------------------------------------
    // Register slave
    // -------------------------------------------------------------
    wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
    rd_go = s_axi_arvalid && !s_q.rvalid;
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      if (s_axi_awaddr[7:0] == REG_CTRL) begin
        for (int i = 0; i < 4; i++) begin
          if (s_axi_wstrb[i]) begin
            s_d.ctrl[i*8 +: 8] = s_axi_wdata[i*8 +: 8];
          end
        end
      end else if (s_axi_awaddr[7:0] != REG_STATUS) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = '0;
      if (s_axi_araddr[7:0] == REG_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (s_axi_araddr[7:0] == REG_STATUS) begin
        s_d.rdata = {3'h0, s_q.code_sync[1], s_q.greset,
                     s_q.fire2, s_q.fire1, s_q.slot_tog,
                     s_q.trk2, s_q.trk1, 1'b0, s_q.enc_n};
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q          <= '0;
      s_q.enc_n    <= '1;
      s_q.code_prev <= '0;
      s_q.ctrl     <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign shared_direction_lines = s_q.shared;
  assign first_slot             = ~s_q.slot_tog;
  assign second_slot            = s_q.slot_tog;
  assign encoder_code_n         = s_q.enc_n;
  assign first_player_tracks    = s_q.trk1;
  assign second_player_tracks   = s_q.trk2;
  assign first_player_fire_out  = s_q.fire1;
  assign second_player_fire_out = s_q.fire2;
  assign first_player_strobe    = s_q.stb1;
  assign second_player_strobe   = s_q.stb2;
  assign game_reset_out         = s_q.greset;
  assign s_axi_awready          = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign s_axi_wready           = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign s_axi_bvalid           = s_q.bvalid;
  assign s_axi_bresp            = s_q.bresp;
  assign s_axi_arready          = !s_q.rvalid;
  assign s_axi_rvalid           = s_q.rvalid;
  assign s_axi_rresp            = s_q.rresp;
  assign s_axi_rdata            = s_q.rdata;

endmodule

// ==== trc_codec_checker.sv ====
// Concurrent checks on the tank remote codec ports
`timescale 1ns/100ps
module trc_codec_checker
  import trc_pkg::*;
#(
  parameter int unsigned REF_DIV_P = REF_DIV // Cycles per tick
) (
  input wire logic        mclk,                      // Clock
  input wire logic        reset_n,                   // Sync reset
  input wire logic [3:0]  first_player_direction_in, // P1 switches
  input wire logic        game_reset_request,        // Reset switch
  input wire logic [4:0]  received_code,             // Decoder code
  input wire logic [3:0]  shared_direction_lines,    // Muxed lines
  input wire logic        first_slot,                // Slot one
  input wire logic        second_slot,               // Slot two
  input wire logic [10:0] encoder_code_n,            // Encoder code
  input wire logic [3:0]  first_player_tracks,       // P1 tracks
  input wire logic [3:0]  second_player_tracks,      // P2 tracks
  input wire logic        first_player_strobe,       // P1 strobe
  input wire logic        second_player_strobe,      // P2 strobe
  input wire logic        game_reset_out             // Game reset
);
  localparam int SLOT = 100 * REF_DIV_P;
  logic [31:0] run_q;
  logic        prev_q;
  // ----------------------------------------------------------------
  // Slot run length
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    prev_q <= first_slot;
    if (!reset_n || first_slot != prev_q) run_q <= '0;
    else run_q <= run_q + 32'd1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_slots_exclusive: assert property (first_slot ^ second_slot)
    else $error("slot lines not complementary");
  // Slot after reset runs one cycle longer than the rest
  a_slot_length: assert property (
    first_slot != prev_q |-> run_q >= SLOT-1)
    else $error("slot ended early");
  a_slot_bound: assert property (run_q <= SLOT)
    else $error("slot overran");
  a_mux_first: assert property (
    (first_slot && $stable(first_player_direction_in))[*5] |->
    shared_direction_lines == first_player_direction_in)
    else $error("shared lines not player one");
  a_code_active: assert property (
    $past(reset_n) |-> encoder_code_n != 11'h7ff)
    else $error("slot without a command");
  a_reset_seize: assert property (
    (game_reset_request && first_slot)[*6] |-> encoder_code_n == 11'h77d)
    else $error("reset code missing");
  a_strobe_pulse: assert property (
    first_player_strobe || second_player_strobe |=>
    !(first_player_strobe || second_player_strobe))
    else $error("strobe longer than one cycle");
  a_strobe_one: assert property (
    first_player_strobe |->
    $past(received_code[4], 4) && !second_player_strobe)
    else $error("player one strobe for wrong code");
  a_strobe_two: assert property (
    second_player_strobe |-> !$past(received_code[4], 4))
    else $error("player two strobe for wrong code");
  a_tracks_hold: assert property (
    ($stable(first_player_tracks) || first_player_strobe) &&
    ($stable(second_player_tracks) || second_player_strobe))
    else $error("tracks changed without strobe");
  a_reset_decode: assert property (
    $rose(game_reset_out) |-> $past(received_code[4:1], 4) == 4'h2)
    else $error("game reset from wrong code");
  a_reset_release: assert property (
    (received_code == 5'h00)[*5] |-> !game_reset_out)
    else $error("game reset stuck");
  cover property (first_player_strobe);
  cover property (second_player_strobe);
  cover property ($rose(game_reset_out));
  cover property (second_slot && encoder_code_n != 11'h7ff);
endmodule
bind trc_codec trc_codec_checker #(.REF_DIV_P(REF_DIV_P))
  trc_codec_checker_inst (
  .mclk(mclk), .reset_n(reset_n),
  .first_player_direction_in(first_player_direction_in),
  .game_reset_request(game_reset_request), .received_code(received_code),
  .shared_direction_lines(shared_direction_lines),
  .first_slot(first_slot), .second_slot(second_slot),
  .encoder_code_n(encoder_code_n), .first_player_tracks(first_player_tracks),
  .second_player_tracks(second_player_tracks),
  .first_player_strobe(first_player_strobe),
  .second_player_strobe(second_player_strobe),
  .game_reset_out(game_reset_out));

// ==== trc_pkg.sv ====
// Constants shared by the tank remote codec
package trc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned REF_HZ       = 500;
  localparam int unsigned REF_DIV      = CLK_HZ / REF_HZ;
  localparam logic [3:0]  DECADE_LAST  = 4'h9;
  localparam int unsigned SETTLE_US    = 1000;
  localparam int unsigned SETTLE_CYC   = CLK_HZ / 1_000_000 * SETTLE_US;
  localparam int unsigned CODE_PULSE_MS = 23;
  localparam int unsigned CODE_REPEAT_MS = 185;

  // ---------------------------------------------------------------
  // Direction switch bits and track bits
  // ---------------------------------------------------------------
  localparam int DIR_FWD = 0;
  localparam int DIR_REV = 1;
  localparam int DIR_LEFT = 2;
  localparam int DIR_RIGHT = 3;
  localparam int TRK_LF = 0;
  localparam int TRK_LR = 1;
  localparam int TRK_RF = 2;
  localparam int TRK_RR = 3;

  // ---------------------------------------------------------------
  // Encoder input lines (active low at the pins)
  // ---------------------------------------------------------------
  localparam int ENC_A = 0;
  localparam int ENC_B = 1;
  localparam int ENC_C = 2;
  localparam int ENC_D = 3;
  localparam int ENC_E = 4;
  localparam int ENC_F = 5;
  localparam int ENC_G = 6;
  localparam int ENC_H = 7;
  localparam int ENC_J = 8;
  localparam int ENC_K = 9;
  localparam int ENC_L = 10;
  localparam int ENC_W = 11;

  // ---------------------------------------------------------------
  // Received 5-bit code fields
  // ---------------------------------------------------------------
  localparam int CODE_FIRE = 0;
  localparam int CODE_DIR_LO = 1;
  localparam int CODE_DIR_HI = 3;
  localparam int CODE_PLAYER = 4;
  localparam logic [2:0] P1_STOP  = 3'h4;
  localparam logic [2:0] P1_FWD   = 3'h0;
  localparam logic [2:0] P1_REV   = 3'h3;
  localparam logic [2:0] P1_LEFT  = 3'h2;
  localparam logic [2:0] P1_RIGHT = 3'h1;
  localparam logic [2:0] P2_FWD   = 3'h4;
  localparam logic [2:0] P2_REV   = 3'h7;
  localparam logic [2:0] P2_LEFT  = 3'h6;
  localparam logic [2:0] P2_RIGHT = 3'h5;
  localparam logic [2:0] P2_RESET = 3'h2;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_RX_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== trc_rx_model.sv ====
// Behavioural model of the ultrasonic code receiver outputs
`timescale 1ns/100ps
module trc_rx_model (
  output logic      [4:0] code_pins, // Parallel code
  input  wire logic       mclk       // Clock
);
  initial code_pins = 5'h00;
  // Whole word appears at once; zero marks the gap between pulses
  task automatic send(input logic [4:0] code, input int len, input int gap);
    @(posedge mclk);
    code_pins <= code;
    repeat (len) @(posedge mclk);
    code_pins <= 5'h00;
    repeat (gap) @(posedge mclk);
  endtask
endmodule
